// ==== rtl/ocs_top.sv ====
// apb register file and output clock source selection for eight outputs
// assumes tap inputs are synchronous levels sampled on core_clk_i
`timescale 1ns/100ps
`default_nettype none

module ocs_top
    import ocs_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        gp_synth_a_div_a_i,
    input  wire logic        gp_synth_a_div_b_i,
    input  wire logic        gp_synth_a_div_c_i,
    input  wire logic        gp_synth_a_div_d_i,
    input  wire logic        gp_synth_b_div_a_i,
    input  wire logic        gp_synth_b_div_c_i,
    input  wire logic        gp_synth_b_div_d_i,
    input  wire logic        hp_synth_a_div_c_i,
    input  wire logic        hp_synth_a_div_d_i,
    input  wire logic        hp_synth_b_div_c_i,
    input  wire logic        hp_synth_b_div_d_i,
    output logic             cfg_clock_pin_0_o,
    output logic             cfg_clock_pin_1_o,
    output logic             cfg_clock_pin_2_o,
    output logic             cfg_clock_pin_3_o,
    output logic             cfg_clock_pin_4_o,
    output logic             cfg_clock_pin_5_o,
    output logic             cfg_clock_pin_6_o,
    output logic             cfg_clock_pin_7_o,
    output logic      [7:0]  pin_enable_o
);

    // ********************************
    // register file
    // ********************************
    logic [7:0]  sel_lower;
    logic [7:0]  sel_upper;
    logic [7:0]  mode_lower;
    logic [7:0]  mode_upper;
    logic [7:0]  next_sel_lower;
    logic [7:0]  next_sel_upper;
    logic [7:0]  next_mode_lower;
    logic [7:0]  next_mode_upper;
    logic        wr_fire;
    logic        hit;
    logic [7:0]  rd_byte;

    // ********************************
    // apb answer
    // ********************************
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        setup_phase;

    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        case (paddr_i)
            ADDR_SEL_LO:  rd_byte = sel_lower;
            ADDR_SEL_UP:  rd_byte = sel_upper;
            ADDR_MODE_LO: rd_byte = mode_lower;
            ADDR_MODE_UP: rd_byte = mode_upper;
            default:      hit = 1'b0;
        endcase
    end

    // the answer is prepared in the setup cycle so that every bus output
    // leaves a flop; the cost is one access cycle per transfer
    assign setup_phase = psel_i & ~penable_i;

    always_comb begin
        next_pready  = setup_phase;
        next_pslverr = setup_phase & ~hit;
        next_prdata  = prdata_o;
        if (setup_phase) begin
            next_prdata = (hit & ~pwrite_i) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // a write lands at the edge that completes the access phase
    assign wr_fire = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];

    always_comb begin
        next_sel_lower  = sel_lower;
        next_sel_upper  = sel_upper;
        next_mode_lower = mode_lower;
        next_mode_upper = mode_upper;
        if (wr_fire) begin
            case (paddr_i)
                ADDR_SEL_LO:  next_sel_lower = pwdata_i[7:0]; // R15
                ADDR_SEL_UP:  next_sel_upper = pwdata_i[7:0]; // R15
                // reserved bits 3 and 7 are dropped so they read as zero
                ADDR_MODE_LO: next_mode_lower = pwdata_i[7:0] & MODE_MASK; // R14
                ADDR_MODE_UP: next_mode_upper = pwdata_i[7:0] & MODE_MASK; // R14
                default:      next_sel_lower = sel_lower;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_lower  <= SEL_RST;
            sel_upper  <= SEL_RST;
            mode_lower <= MODE_RST;
            mode_upper <= MODE_RST;
        end else begin
            sel_lower  <= next_sel_lower;
            sel_upper  <= next_sel_upper;
            mode_lower <= next_mode_lower;
            mode_upper <= next_mode_upper;
        end
    end

    // ********************************
    // source taps per pair
    // ********************************
    // hp synth taps feeding a differential pair need the matching gp synth
    // running; software keeps to that, this block cannot check it
    logic [3:0]  gp_even;
    logic [3:0]  hp_even;
    logic [3:0]  gp_odd;
    logic [3:0]  hp_odd;
    logic [15:0] sel_word;
    logic [15:0] mode_word;
    logic [7:0]  next_pin;
    logic [7:0]  next_en;
    logic [7:0]  pin;

    // R1 R4 R5 R8
    assign gp_even = {gp_synth_b_div_a_i, gp_synth_b_div_a_i,
                      gp_synth_a_div_c_i, gp_synth_a_div_a_i};
    assign hp_even = {hp_synth_b_div_c_i, hp_synth_b_div_c_i,
                      hp_synth_a_div_d_i, hp_synth_a_div_c_i};
    // R2 R6 R9 R13
    assign gp_odd  = {gp_synth_b_div_d_i, gp_synth_b_div_c_i,
                      gp_synth_a_div_d_i, gp_synth_a_div_b_i};
    assign hp_odd  = {hp_synth_b_div_d_i, hp_synth_b_div_d_i,
                      hp_synth_a_div_d_i, hp_synth_a_div_c_i};

    assign sel_word  = {sel_upper, sel_lower};
    assign mode_word = {mode_upper, mode_lower};

    // ********************************
    // pair selection
    // ********************************
    genvar p;
    generate
        for (p = 0; p < PAIRS; p = p + 1) begin : g_pair
            ocs_pair_mux u_mux (
                .mode_i     (mode_word[FIELD_STP*p +: MODE_W]),
                .sel_even_i (sel_word[FIELD_STP*p +: SEL_W]),
                .sel_odd_i  (sel_word[FIELD_STP*p+SEL_W +: SEL_W]),
                .gp_even_i  (gp_even[p]),
                .hp_even_i  (hp_even[p]),
                .gp_odd_i   (gp_odd[p]),
                .hp_odd_i   (hp_odd[p]),
                .clk_even_o (next_pin[2*p]),
                .clk_odd_o  (next_pin[2*p+1]),
                .en_even_o  (next_en[2*p]),
                .en_odd_o   (next_en[2*p+1])
            ); // R3 R7 R10 R13 R14
        end
    endgenerate

    // ********************************
    // output stage
    // ********************************
    // one flop stage keeps even and odd of a pair aligned, so the
    // inverted partner never leads or lags by a gate delay
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin          <= 8'h00;
            pin_enable_o <= 8'h00;
        end else begin
            pin          <= next_pin;
            pin_enable_o <= next_en;
        end
    end

    assign cfg_clock_pin_0_o = pin[0];
    assign cfg_clock_pin_1_o = pin[1];
    assign cfg_clock_pin_2_o = pin[2];
    assign cfg_clock_pin_3_o = pin[3];
    assign cfg_clock_pin_4_o = pin[4];
    assign cfg_clock_pin_5_o = pin[5];
    assign cfg_clock_pin_6_o = pin[6];
    assign cfg_clock_pin_7_o = pin[7];

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    logic diff_01;
    logic diff_23;
    logic diff_45;
    logic diff_67;

    assign diff_01 = mode_lower[2:0] inside {MODE_COMPL, MODE_HCSL, MODE_PECL};
    assign diff_23 = mode_lower[6:4] inside {MODE_COMPL, MODE_HCSL, MODE_PECL};
    assign diff_45 = mode_upper[2:0] inside {MODE_COMPL, MODE_HCSL, MODE_PECL};
    assign diff_67 = mode_upper[6:4] inside {MODE_COMPL, MODE_HCSL, MODE_PECL};

    out0_src_a: assert property ( // R1
        (sel_lower[1:0] == SRC_GP) |=> (pin[0] == $past(gp_synth_a_div_a_i)))
        else $error("output 0 not following gp A div A");

    out0_hp_a: assert property ( // R1
        (sel_lower[1:0] == SRC_HP) |=> (pin[0] == $past(hp_synth_a_div_c_i)))
        else $error("output 0 not following hp A div C");

    out1_src_a: assert property ( // R2
        (!diff_01 && sel_lower[3:2] == SRC_GP)
        |=> (pin[1] == $past(gp_synth_a_div_b_i)))
        else $error("output 1 not following gp A div B");

    out1_diff_a: assert property ( // R3
        diff_01 |=> (pin[1] != pin[0]))
        else $error("output 1 not inverse of output 0");

    out2_src_a: assert property ( // R4
        (sel_lower[5:4] == SRC_HP) |=> (pin[2] == $past(hp_synth_a_div_d_i)))
        else $error("output 2 not following hp A div D");

    out3_src_a: assert property ( // R13
        diff_23 |=> (pin[3] != pin[2]))
        else $error("output 3 not inverse of output 2");

    out4_src_a: assert property ( // R5
        (sel_upper[1:0] == SRC_GP) |=> (pin[4] == $past(gp_synth_b_div_a_i)))
        else $error("output 4 not following gp B div A");

    out5_src_a: assert property ( // R6
        (!diff_45 && sel_upper[3:2] == SRC_HP)
        |=> (pin[5] == $past(hp_synth_b_div_d_i)))
        else $error("output 5 not following hp B div D");

    out5_diff_a: assert property ( // R7
        diff_45 |=> (pin[5] != pin[4]))
        else $error("output 5 not inverse of output 4");

    out6_src_a: assert property ( // R8
        (sel_upper[5:4] == SRC_HP) |=> (pin[6] == $past(hp_synth_b_div_c_i)))
        else $error("output 6 not following hp B div C");

    out7_src_a: assert property ( // R9
        (!diff_67 && sel_upper[7:6] == SRC_GP)
        |=> (pin[7] == $past(gp_synth_b_div_d_i)))
        else $error("output 7 not following gp B div D");

    out7_diff_a: assert property ( // R10
        diff_67 |=> (pin[7] != pin[6]))
        else $error("output 7 not inverse of output 6");

    pair_off_a: assert property ( // R14
        (mode_lower[2:0] == MODE_OFF) |=> (pin_enable_o[1:0] == 2'h0))
        else $error("pair 0 enabled while mode is off");

    sel_write_a: assert property ( // R15
        (wr_fire && paddr_i == ADDR_SEL_LO)
        ##1 (psel_i && !penable_i && !pwrite_i && paddr_i == ADDR_SEL_LO)
        |=> (prdata_o[7:0] == $past(pwdata_i[7:0], 2)))
        else $error("select readback differs from last write");

    reserved_low_a: assert property ( // R1
        (sel_lower[1] == 1'b1) |=> (pin[0] == 1'b0))
        else $error("reserved select code drives output 0");

    out1_hp_a: assert property ( // R2
        (!diff_01 && sel_lower[3:2] == SRC_HP)
        |=> (pin[1] == $past(hp_synth_a_div_c_i)))
        else $error("output 1 not following hp A div C");

    out2_gp_a: assert property ( // R4
        (sel_lower[5:4] == SRC_GP) |=> (pin[2] == $past(gp_synth_a_div_c_i)))
        else $error("output 2 not following gp A div C");

    out3_gp_a: assert property ( // R13
        (!diff_23 && sel_lower[7:6] == SRC_GP)
        |=> (pin[3] == $past(gp_synth_a_div_d_i)))
        else $error("output 3 not following gp A div D");

    out3_hp_a: assert property ( // R13
        (!diff_23 && sel_lower[7:6] == SRC_HP)
        |=> (pin[3] == $past(hp_synth_a_div_d_i)))
        else $error("output 3 not following hp A div D");

    out4_hp_a: assert property ( // R5
        (sel_upper[1:0] == SRC_HP) |=> (pin[4] == $past(hp_synth_b_div_c_i)))
        else $error("output 4 not following hp B div C");

    out5_gp_a: assert property ( // R6
        (!diff_45 && sel_upper[3:2] == SRC_GP)
        |=> (pin[5] == $past(gp_synth_b_div_c_i)))
        else $error("output 5 not following gp B div C");

    out6_gp_a: assert property ( // R8
        (sel_upper[5:4] == SRC_GP) |=> (pin[6] == $past(gp_synth_b_div_a_i)))
        else $error("output 6 not following gp B div A");

    out7_hp_a: assert property ( // R9
        (!diff_67 && sel_upper[7:6] == SRC_HP)
        |=> (pin[7] == $past(hp_synth_b_div_d_i)))
        else $error("output 7 not following hp B div D");

    reserved_up_a: assert property ( // R9
        (!diff_67 && sel_upper[7] == 1'b1)
        |=> (pin[7] == 1'b0))
        else $error("reserved select code drives output 7");

    pair_diff_a: assert property ( // R14
        diff_01 |=> (pin_enable_o[1:0] == 2'h3))
        else $error("differential pair 0 not fully enabled");

    upper_off_a: assert property ( // R14
        (mode_upper[6:4] == MODE_OFF) |=> (pin_enable_o[7:6] == 2'h0))
        else $error("pair 3 enabled while mode is off");

    ready_pulse_a: assert property ( // R15
        pready_o |=> !pready_o)
        else $error("ready held longer than one access cycle");

endmodule

`default_nettype wire

// ==== rtl/ocs_pkg.sv ====
// constants, field layout and encodings of the output clock source select
// assumes an apb slave with 32-bit data and one aligned word per register
// Contract
// [R1] out 0 takes gp A div A on 00, hp A div C on 01
// [R2] out 1 single ended: gp A div B on 00, hp A div C on 01
// [R3] pair 0/1 differential: out 1 is inverted out 0, its field ignored
// [R4] out 2 takes gp A div C on 00, hp A div D on 01
// [R5] out 4 takes gp B div A on 00, hp B div C on 01
// [R6] out 5 single ended: gp B div C on 00, hp B div D on 01
// [R7] pair 4/5 differential: out 5 is inverted out 4, its field ignored
// [R8] out 6 takes gp B div A on 00, hp B div C on 01
// [R9] out 7 single ended: gp B div D on 00, hp B div D on 01
// [R10] pair 6/7 differential: out 7 is inverted out 6, its field ignored
// [R11] software enables gp synth B before using hp synth B differentially
// [R12] software enables gp synth A before using hp synth A differentially
// [R13] out 3 single: gp A div D / hp A div D; differential: inverted out 2
// [R14] pair mode field picks off, cmos variants, hcsl 101 or pecl 110
// [R15] written select takes effect; reads return last write, zero after reset

package ocs_pkg;

    // ********************************
    // register map
    // ********************************
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam logic [9:0]  IDX_MODE_UP  = 10'h0B2;
    localparam logic [9:0]  IDX_MODE_LO  = 10'h0B3;
    localparam logic [9:0]  IDX_SEL_UP   = 10'h0B4;
    localparam logic [9:0]  IDX_SEL_LO   = 10'h0B5;
    localparam logic [11:0] ADDR_MODE_UP = {IDX_MODE_UP, 2'b00};
    localparam logic [11:0] ADDR_MODE_LO = {IDX_MODE_LO, 2'b00};
    localparam logic [11:0] ADDR_SEL_UP  = {IDX_SEL_UP, 2'b00};
    localparam logic [11:0] ADDR_SEL_LO  = {IDX_SEL_LO, 2'b00};

    // ********************************
    // fields and reset values
    // ********************************
    localparam int          REG_W     = 8;
    localparam int          SEL_W     = 2;
    localparam int          MODE_W    = 3;
    localparam int          PAIRS     = 4;
    localparam int          FIELD_STP = 4;
    localparam logic [7:0]  SEL_RST   = 8'h00;
    localparam logic [7:0]  MODE_RST  = 8'h00;
    localparam logic [7:0]  MODE_MASK = 8'h77;

    typedef enum logic [1:0] {
        SRC_GP   = 2'b00,
        SRC_HP   = 2'b01,
        SRC_RSV2 = 2'b10,
        SRC_RSV3 = 2'b11
    } ocs_src_t;

    typedef enum logic [2:0] {
        MODE_OFF   = 3'b000,
        MODE_EVEN  = 3'b001,
        MODE_ODD   = 3'b010,
        MODE_DUAL  = 3'b011,
        MODE_COMPL = 3'b100,
        MODE_HCSL  = 3'b101,
        MODE_PECL  = 3'b110,
        MODE_RSV   = 3'b111
    } ocs_mode_t;

endpackage

// ==== rtl/ocs_pair_mux.sv ====
// source selection for one even/odd output pair, purely combinational
// assumes the caller registers the results
`timescale 1ns/100ps
`default_nettype none

module ocs_pair_mux
    import ocs_pkg::*;
(
    input  wire logic [2:0] mode_i,
    input  wire logic [1:0] sel_even_i,
    input  wire logic [1:0] sel_odd_i,
    input  wire logic       gp_even_i,
    input  wire logic       hp_even_i,
    input  wire logic       gp_odd_i,
    input  wire logic       hp_odd_i,
    output logic            clk_even_o,
    output logic            clk_odd_o,
    output logic            en_even_o,
    output logic            en_odd_o
);

    logic odd_single;

    always_comb begin
        case (sel_even_i)
            SRC_GP:  clk_even_o = gp_even_i;
            SRC_HP:  clk_even_o = hp_even_i;
            default: clk_even_o = 1'b0;
        endcase
        odd_single = 1'b0;
        case (sel_odd_i)
            SRC_GP:  odd_single = gp_odd_i;
            SRC_HP:  odd_single = hp_odd_i;
            default: odd_single = 1'b0;
        endcase
        // complementary and both differential modes ignore the odd field
        case (mode_i)
            MODE_EVEN: begin
                en_even_o = 1'b1;
                en_odd_o  = 1'b0;
                clk_odd_o = odd_single;
            end
            MODE_ODD: begin
                en_even_o = 1'b0;
                en_odd_o  = 1'b1;
                clk_odd_o = odd_single;
            end
            MODE_DUAL: begin
                en_even_o = 1'b1;
                en_odd_o  = 1'b1;
                clk_odd_o = odd_single;
            end
            MODE_COMPL, MODE_HCSL, MODE_PECL: begin
                en_even_o = 1'b1;
                en_odd_o  = 1'b1;
                clk_odd_o = ~clk_even_o;
            end
            default: begin
                en_even_o = 1'b0;
                en_odd_o  = 1'b0;
                clk_odd_o = odd_single;
            end
        endcase
    end

endmodule

`default_nettype wire

// ==== dv/ocs_tap_source.sv ====
// model of the synthesizer post-divider taps feeding the source select
// assumes one clock; taps change by non-blocking assignment after each rising edge
`timescale 1ns/100ps
`default_nettype none

module ocs_tap_source (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    output logic      [10:0] tap_o
);
    logic [15:0] acc;
    logic [15:0] next_acc;

    // odd step scrambles every bit, so no two taps track each other
    always_comb begin
        next_acc = acc + 16'h9E37;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc <= 16'h0000;
        end else begin
            acc <= next_acc;
        end
    end

    assign tap_o = acc[15:5];
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench: apb register access and per-pin source checks
// assumes ocs_pkg, ocs_top and the tap source model are compiled first
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import ocs_pkg::*;
;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [10:0] tap, tap_q;
    logic [7:0]  pins, pin_en, sel_lo, sel_up, mode_lo, mode_up;
    logic        err;
    int          n_mismatch, compares;
    logic [7:0]  sel_tab [6] = '{8'h00, 8'h55, 8'h11, 8'h44, 8'hAA, 8'hE4};

    ocs_top ocs_top_inst (
        .core_clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .gp_synth_a_div_a_i(tap[0]), .gp_synth_a_div_b_i(tap[1]),
        .gp_synth_a_div_c_i(tap[2]), .gp_synth_a_div_d_i(tap[3]),
        .gp_synth_b_div_a_i(tap[4]), .gp_synth_b_div_c_i(tap[5]),
        .gp_synth_b_div_d_i(tap[6]), .hp_synth_a_div_c_i(tap[7]),
        .hp_synth_a_div_d_i(tap[8]), .hp_synth_b_div_c_i(tap[9]),
        .hp_synth_b_div_d_i(tap[10]),
        .cfg_clock_pin_0_o(pins[0]), .cfg_clock_pin_1_o(pins[1]),
        .cfg_clock_pin_2_o(pins[2]), .cfg_clock_pin_3_o(pins[3]),
        .cfg_clock_pin_4_o(pins[4]), .cfg_clock_pin_5_o(pins[5]),
        .cfg_clock_pin_6_o(pins[6]), .cfg_clock_pin_7_o(pins[7]),
        .pin_enable_o(pin_en)
    );

    ocs_tap_source ocs_tap_source_inst (.clk_i(clk), .resetn_i(resetn), .tap_o(tap));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // the design's output flop sees the same tap sample as this copy
    always_ff @(posedge clk) begin
        tap_q <= tap;
    end

    task automatic report_and_stop;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_pins(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer, entered right after a rising edge; the caller releases the bus
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            input logic s0);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= {3'b000, s0};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // read before this edge's updates land, so these are the sampled values
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        rd  = prdata;
        err = pslverr;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic s0);
        @(posedge clk);
        apb_xfer(wr, a, d, s0);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0, 1'b1);
        cmp_word(rd, {24'h0, exp});
        cmp_word({31'h0, err}, 32'h0);
    endtask

    // ********************************
    // reference of pins and enables
    // ********************************
    function automatic logic pick(input logic [1:0] c, input logic g, input logic h);
        return (c == 2'b00) ? g : ((c == 2'b01) ? h : 1'b0);
    endfunction

    function automatic logic dif(input logic [2:0] m);
        return m inside {3'b100, 3'b101, 3'b110};
    endfunction

    function automatic logic [1:0] en_of(input logic [2:0] m);
        return (m == 3'b000 || m == 3'b111) ? 2'b00 : ((m == 3'b001) ? 2'b01 :
               ((m == 3'b010) ? 2'b10 : 2'b11));
    endfunction

    function automatic logic [7:0] exp_pins(input logic [10:0] t);
        logic [7:0] p;
        p[0] = pick(sel_lo[1:0], t[0], t[7]);
        p[1] = dif(mode_lo[2:0]) ? ~p[0] : pick(sel_lo[3:2], t[1], t[7]);
        p[2] = pick(sel_lo[5:4], t[2], t[8]);
        p[3] = dif(mode_lo[6:4]) ? ~p[2] : pick(sel_lo[7:6], t[3], t[8]);
        p[4] = pick(sel_up[1:0], t[4], t[9]);
        p[5] = dif(mode_up[2:0]) ? ~p[4] : pick(sel_up[3:2], t[5], t[10]);
        p[6] = pick(sel_up[5:4], t[4], t[9]);
        p[7] = dif(mode_up[6:4]) ? ~p[6] : pick(sel_up[7:6], t[6], t[10]);
        return p;
    endfunction

    task automatic check_pins(input int n);
        repeat (n) begin
            @(negedge clk);
            cmp_pins(pins, exp_pins(tap_q));
            cmp_pins(pin_en, {en_of(mode_up[6:4]), en_of(mode_up[2:0]),
                              en_of(mode_lo[6:4]), en_of(mode_lo[2:0])});
        end
    endtask

    // reserved bits 3 and 7 of the mode bytes are written set and must read back clear
    task automatic set_cfg(input logic [7:0] ml, input logic [7:0] mu,
                           input logic [7:0] sl, input logic [7:0] su);
        apb(1'b1, ADDR_MODE_LO, {24'h0, ml | 8'h88}, 1'b1);
        apb(1'b1, ADDR_MODE_UP, {24'h0, mu | 8'h88}, 1'b1);
        apb(1'b1, ADDR_SEL_LO, {24'hFFFFFF, sl}, 1'b1);
        apb(1'b1, ADDR_SEL_UP, {24'hFFFFFF, su}, 1'b1);
        mode_lo = ml & MODE_MASK;
        mode_up = mu & MODE_MASK;
        sel_lo  = sl;
        sel_up  = su;
        rd_chk(ADDR_MODE_LO, mode_lo);
        rd_chk(ADDR_MODE_UP, mode_up);
        rd_chk(ADDR_SEL_LO, sel_lo);
        rd_chk(ADDR_SEL_UP, sel_up);
    endtask

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {sel_lo, sel_up, mode_lo, mode_up} = '0;
        n_mismatch = 0;
        compares   = 0;
        repeat (8) @(posedge clk);
        cmp_pins(pins, 8'h00);
        cmp_pins(pin_en, 8'h00);
        resetn <= 1'b1;
        rd_chk(ADDR_SEL_LO, SEL_RST);
        rd_chk(ADDR_SEL_UP, SEL_RST);
        rd_chk(ADDR_MODE_LO, MODE_RST);
        check_pins(4);
        apb(1'b1, 12'h2D8, 32'hFF, 1'b1);
        cmp_word({31'h0, err}, 32'h1);
        apb(1'b0, 12'h2D8, 32'h0, 1'b1);
        cmp_word({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, ADDR_SEL_LO, 32'hFF, 1'b0);
        rd_chk(ADDR_SEL_LO, 8'h00);
        // write then read with no idle cycle between them
        @(posedge clk);
        apb_xfer(1'b1, ADDR_SEL_LO, 32'h0000002D, 1'b1);
        apb_xfer(1'b0, ADDR_SEL_LO, 32'h00000000, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        cmp_word(rd, 32'h0000002D);
        sel_lo = 8'h2D;
        check_pins(4);
        // hp taps in differential modes assume the gp synthesizer is already on
        for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 6; k++) begin
                set_cfg({1'b0, 3'(m), 1'b0, 3'(m + 1)}, {1'b0, 3'(7 - m), 1'b0, 3'(m)},
                        sel_tab[k], sel_tab[(k + 1) % 6]);
                check_pins(12);
            end
        end
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_pins(pins, 8'h00);
        cmp_pins(pin_en, 8'h00);
        resetn <= 1'b1;
        {sel_lo, sel_up, mode_lo, mode_up} = '0;
        rd_chk(ADDR_SEL_UP, 8'h00);
        rd_chk(ADDR_MODE_UP, MODE_RST);
        check_pins(4);
        report_and_stop();
    end
endmodule
`default_nettype wire
